/* dv/random_port_access_control_tb.sv */
// Purpose: Self-checking bench of the random access control
// Assumes: Strobes settle five edges after a pin change, read data six
// Notes: Host model drives pins, bench judges ports
`timescale 1ns/10ps
module random_port_access_control_tb;
   logic core_clk_i = 1'b0;
   logic resetn_i = 1'b0;
   logic [11:0] aaddr;
   wire logic [15:0] mem_rdata_i = {4'ha, aaddr};
   logic [15:0] cmd_rdata_i = 16'h3c5a;
   logic [5:0] pins;
   logic [11:0] addr;
   logic [15:0] hdata, dout, doe, bus, wdata;
   logic mrd, mwl, mwh, crd, cwl, cwh, rel, serr;
   int err_total = 0;
   int num_checks = 0;
   int rel_cnt = 0;
   int cyc = 0;
   assign bus = (dout & doe) | (hdata & ~doe);
   initial forever #50 core_clk_i = ~core_clk_i;
   rpa_host_model host (.core_clk_i(core_clk_i), .pins_o(pins),
      .addr_o(addr), .data_o(hdata));
   rpa_access_ctrl DUT (.core_clk_i(core_clk_i), .resetn_i(resetn_i),
      .chip_sel_n_i(pins[5]), .cmd_sel_n_i(pins[4]),
      .read_write_i(pins[3]), .low_byte_sel_n_i(pins[2]),
      .high_byte_sel_n_i(pins[1]), .out_en_n_i(pins[0]), .addr_i(addr),
      .data_in_i(bus), .data_out_o(dout), .data_oe_o(doe),
      .acc_addr_o(aaddr), .acc_wdata_o(wdata), .mem_rd_o(mrd),
      .mem_wr_lo_o(mwl), .mem_wr_hi_o(mwh), .mem_rdata_i(mem_rdata_i),
      .cmd_rd_o(crd), .cmd_wr_lo_o(cwl), .cmd_wr_hi_o(cwh),
      .cmd_rdata_i(cmd_rdata_i), .seq_release_o(rel),
      .select_error_o(serr));
   always @(posedge core_clk_i) begin
      if (rel === 1'b1) rel_cnt++;
      cyc++;
      if (cyc == 2000) begin
         err_total++;
         report_and_stop();
      end
   end
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      num_checks++;
      #1;
      if (got !== exp) begin
         err_total++;
         $display("ERROR %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic t_read();
      logic [1:0] l;
      for (int i = 0; i < 4; i++) begin
         l = i[1:0];
         host.go({3'b011, l, 1'b0}, 12'h010, 16'h0000);
         chk(16'(mrd), 16'h0001);
         chk(doe, {{8{!l[0]}}, {8{!l[1]}}});
         chk(dout, 16'ha010);
      end
   endtask
   task automatic t_write();
      logic [1:0] l;
      for (int i = 0; i < 4; i++) begin
         l = i[1:0];
         host.go({3'b010, l, 1'b1}, 12'h020, 16'(16'h1234 + i));
         chk(16'(aaddr), 16'h0020);
         chk(16'(mwl), 16'(!l[1]));
         chk(16'(mwh), 16'(!l[0]));
         chk(doe, 16'h0000);
         chk(wdata, 16'(16'h1234 + i));
      end
   endtask
   task automatic t_late();
      host.go(6'b010000, 12'h030, 16'h0f0f);
      chk(doe, 16'h0000);
      host.set(6'b011000);
      chk(doe, 16'h0000);
      chk(16'(mrd), 16'h0000);
   endtask
   task automatic t_cmd();
      rel_cnt = 0;
      host.go(6'b100011, 12'h004, 16'hffef);
      chk(16'(cwl), 16'h0001);
      chk(16'(cwh), 16'h0000);
      chk(16'(mwl), 16'h0000);
      chk(16'(rel_cnt), 16'h0001);
      host.go(6'b100001, 12'h005, 16'hffef);
      chk(16'(cwh), 16'h0001);
      chk(16'(rel_cnt), 16'h0001);
      host.go(6'b100011, 12'h004, 16'h0010);
      chk(16'(rel_cnt), 16'h0001);
      host.go(6'b101010, 12'h004, 16'h0000);
      chk(16'(crd), 16'h0001);
      chk(dout, 16'h3c5a);
   endtask
   task automatic t_clash();
      host.go(6'b001000, 12'h040, 16'h0000);
      chk(16'(serr), 16'h0001);
      chk(16'({mrd, crd, mwl, cwl}), 16'h0000);
      chk(doe, 16'h0000);
   endtask
   task automatic report_and_stop();
      $display("checks %0d errors %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial begin
      repeat (16) @(posedge core_clk_i);
      resetn_i <= 1'b1;
      t_read();
      t_write();
      t_late();
      t_cmd();
      t_clash();
      report_and_stop();
   end
endmodule // random_port_access_control_tb

/* dv/rpa_access_ctrl_assertions.sv */
// Purpose: Port checks of the random access control
// Assumes: Only top module ports are seen
// Notes: Bound into rpa_access_ctrl
`timescale 1ns/10ps
`include "rpa_map.svh"
module rpa_access_ctrl_assertions #(
   parameter int ADDR_W = 12,
   parameter int DATA_W = 16
) (
   input wire logic core_clk_i,
   input wire logic resetn_i,
   input wire logic [DATA_W-1:0] data_out_o,
   input wire logic [DATA_W-1:0] data_oe_o,
   input wire logic [ADDR_W-1:0] acc_addr_o,
   input wire logic [DATA_W-1:0] acc_wdata_o,
   input wire logic mem_rd_o,
   input wire logic mem_wr_lo_o,
   input wire logic mem_wr_hi_o,
   input wire logic [DATA_W-1:0] mem_rdata_i,
   input wire logic cmd_rd_o,
   input wire logic cmd_wr_lo_o,
   input wire logic cmd_wr_hi_o,
   input wire logic seq_release_o,
   input wire logic select_error_o
);
   wire logic wr = mem_wr_lo_o | mem_wr_hi_o | cmd_wr_lo_o | cmd_wr_hi_o;
   wire logic rd = mem_rd_o | cmd_rd_o;
   wire logic ms = mem_rd_o | mem_wr_lo_o | mem_wr_hi_o;
   wire logic cs = cmd_rd_o | cmd_wr_lo_o | cmd_wr_hi_o;
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!resetn_i);
   rd_wr_excl_a: assert property (!(rd && wr))
      else $error("read and write together");
   read_data_a: assert property ($past(mem_rd_o) && mem_rd_o |->
      data_out_o == $past(mem_rdata_i)) else $error("read data wrong");
   wr_no_drive_a: assert property (wr |-> data_oe_o == '0)
      else $error("drive during write");
   sticky_write_a: assert property (wr |=> !rd)
      else $error("write turned to read");
   space_excl_a: assert property (!(ms && cs))
      else $error("both spaces active");
   clash_quiet_a: assert property (select_error_o |->
      !rd && !wr && data_oe_o == '0) else $error("clash not quiet");
   release_cond_a: assert property (seq_release_o |-> cmd_wr_lo_o &&
      acc_addr_o[2:0] == `RPA_RESTART_LOC &&
      !acc_wdata_o[`RPA_RESTART_BIT]) else $error("bad release");
   release_pulse_a: assert property (seq_release_o |=> !seq_release_o)
      else $error("release too long");
   lane_drive_a: assert property (data_oe_o != '0 |-> rd &&
      data_oe_o[7:0] inside {8'h00, 8'hff} &&
      data_oe_o[15:8] inside {8'h00, 8'hff}) else $error("bad lane drive");
endmodule // rpa_access_ctrl_assertions
bind rpa_access_ctrl rpa_access_ctrl_assertions #(.ADDR_W(ADDR_W),
   .DATA_W(DATA_W)) u_chk (.core_clk_i(core_clk_i), .resetn_i(resetn_i),
   .data_out_o(data_out_o), .data_oe_o(data_oe_o), .acc_addr_o(acc_addr_o),
   .acc_wdata_o(acc_wdata_o), .mem_rd_o(mem_rd_o),
   .mem_wr_lo_o(mem_wr_lo_o), .mem_wr_hi_o(mem_wr_hi_o),
   .mem_rdata_i(mem_rdata_i), .cmd_rd_o(cmd_rd_o),
   .cmd_wr_lo_o(cmd_wr_lo_o), .cmd_wr_hi_o(cmd_wr_hi_o),
   .seq_release_o(seq_release_o), .select_error_o(select_error_o));

/* dv/rpa_host_model.sv */
// Purpose: Host side pin driver
// Assumes: Pins change at rising edges
// Notes: Released data lines toggle every cycle
`timescale 1ns/10ps
module rpa_host_model (
   input wire logic core_clk_i,
   output logic [5:0] pins_o,
   output logic [11:0] addr_o,
   output logic [15:0] data_o
);
   logic drv_q = 1'b0;
   logic [15:0] wd_q = 16'h0000;
   initial pins_o = 6'h3f;
   initial addr_o = 12'h000;
   initial data_o = 16'h0000;
   always @(posedge core_clk_i) data_o <= drv_q ? wd_q : ~data_o;
   // Pins cs cmd rw lo hi oe, applied then held
   task automatic set(input logic [5:0] p);
      @(posedge core_clk_i);
      pins_o <= p;
      drv_q <= !p[3];
      repeat (7) @(posedge core_clk_i);
   endtask
   task automatic go(input logic [5:0] p, input logic [11:0] a,
         input logic [15:0] d);
      @(posedge core_clk_i);
      pins_o <= 6'h3f;
      drv_q <= 1'b0;
      repeat (6) @(posedge core_clk_i);
      addr_o <= a;
      wd_q <= d;
      drv_q <= !p[3];
      set(p);
   endtask
endmodule // rpa_host_model

/* include/rpa_map.svh */
// Purpose: Constants of the random port access control
// Assumes: Included by its bare name
// Notes: Definitions only
`ifndef RPA_MAP_SVH
`define RPA_MAP_SVH

// ****************************************
// Control pin vector
// ****************************************
`define RPA_CTRL_W 6
`define RPA_CTRL_RST 6'h3f
`define RPA_POS_CS 5
`define RPA_POS_CMD 4
`define RPA_POS_RW 3
`define RPA_POS_LO 2
`define RPA_POS_HB 1
`define RPA_POS_OE 0

// ****************************************
// Command space
// ****************************************
`define RPA_CMD_AW 3
`define RPA_RESTART_LOC 3'h4
`define RPA_RESTART_BIT 4

// ****************************************
// Lane width and sync stages
// ****************************************
`define RPA_LANE_W 8
`define RPA_SYNC_STAGES 3

`endif

/* include/rpa_pkg.sv */
// Purpose: Types of the random port access control
// Assumes: Nothing
// Notes: Constants live in rpa_map.svh
package rpa_pkg;

   typedef enum logic [1:0] {
      RPA_IDLE,
      RPA_READ,
      RPA_WRITE,
      RPA_CLASH
   } rpa_state_e;

endpackage

/* src/rpa_access_ctrl.sv */
// Purpose: Random access port control of a dual port buffer
// Assumes: Host pins asynchronous, sampled on core_clk_i
// Notes: Data pin is split into input, output and enable
`timescale 1ns/10ps
`include "rpa_map.svh"

// How it works
// - Read/write high while selected means read
// - Write only selected lanes, rw and select low
// - Select after write low: never drive outputs
// - Undriven write cycle keeps pins released throughout
// - Memory and command spaces never selected together
// - Command location four, bit four zero, releases
module rpa_access_ctrl #(
   parameter int ADDR_W = 12,
   parameter int DATA_W = 16
) (
   input wire logic core_clk_i,
   input wire logic resetn_i,
   input wire logic chip_sel_n_i,
   input wire logic cmd_sel_n_i,
   input wire logic read_write_i,
   input wire logic low_byte_sel_n_i,
   input wire logic high_byte_sel_n_i,
   input wire logic out_en_n_i,
   input wire logic [ADDR_W-1:0] addr_i,
   input wire logic [DATA_W-1:0] data_in_i,
   output logic [DATA_W-1:0] data_out_o,
   output logic [DATA_W-1:0] data_oe_o,
   output logic [ADDR_W-1:0] acc_addr_o,
   output logic [DATA_W-1:0] acc_wdata_o,
   output logic mem_rd_o,
   output logic mem_wr_lo_o,
   output logic mem_wr_hi_o,
   input wire logic [DATA_W-1:0] mem_rdata_i,
   output logic cmd_rd_o,
   output logic cmd_wr_lo_o,
   output logic cmd_wr_hi_o,
   input wire logic [DATA_W-1:0] cmd_rdata_i,
   output logic seq_release_o,
   output logic select_error_o
);

   localparam int IN_W = `RPA_CTRL_W + ADDR_W + DATA_W;
   localparam logic [IN_W-1:0] IN_RST = {`RPA_CTRL_RST,
                                         {(ADDR_W + DATA_W){1'b0}}};

   logic [IN_W-1:0] pins_s;
   logic [`RPA_CTRL_W-1:0] ctl_s;
   logic [ADDR_W-1:0] addr_s;
   logic [DATA_W-1:0] data_s;
   logic cs_n;
   logic cmd_n;
   logic rw;
   logic lo_n;
   logic hb_n;
   logic oe_n;
   logic mem_sel;
   logic cmd_sel;
   logic any_sel;
   logic both_sel;
   rpa_pkg::rpa_state_e state_q;
   rpa_pkg::rpa_state_e state_d;
   logic space_cmd_q;
   logic space_cmd_d;
   logic released_q;
   logic wr_lo;
   logic wr_hi;
   logic rel_hit;

   // ****************************************
   // Pin synchronisers
   // ****************************************
   rpa_pin_sync #(
      .W(IN_W),
      .RST_VAL(IN_RST)
   ) u_sync (
      .core_clk_i(core_clk_i),
      .resetn_i(resetn_i),
      .pin_i({chip_sel_n_i, cmd_sel_n_i, read_write_i, low_byte_sel_n_i,
              high_byte_sel_n_i, out_en_n_i, addr_i, data_in_i}),
      .level_o(pins_s)
   );

   assign ctl_s = pins_s[IN_W-1 -: `RPA_CTRL_W];
   assign addr_s = pins_s[DATA_W +: ADDR_W];
   assign data_s = pins_s[DATA_W-1:0];
   assign cs_n = ctl_s[`RPA_POS_CS];
   assign cmd_n = ctl_s[`RPA_POS_CMD];
   assign rw = ctl_s[`RPA_POS_RW];
   assign lo_n = ctl_s[`RPA_POS_LO];
   assign hb_n = ctl_s[`RPA_POS_HB];
   assign oe_n = ctl_s[`RPA_POS_OE];

   // ****************************************
   // Space decode
   // ****************************************
   assign mem_sel = !cs_n && cmd_n;
   assign cmd_sel = !cmd_n && cs_n;
   assign any_sel = mem_sel || cmd_sel;
   assign both_sel = !cs_n && !cmd_n;

   // ****************************************
   // Access state
   // ****************************************
   always_comb begin
      state_d = state_q;
      space_cmd_d = space_cmd_q;
      case (state_q)
         rpa_pkg::RPA_IDLE: begin
            if (both_sel) begin
               state_d = rpa_pkg::RPA_CLASH;
            end else if (any_sel) begin
               space_cmd_d = cmd_sel;
               if (rw) begin
                  state_d = rpa_pkg::RPA_READ;
               end else begin
                  state_d = rpa_pkg::RPA_WRITE;
               end
            end
         end
         rpa_pkg::RPA_READ: begin
            if (both_sel) begin
               state_d = rpa_pkg::RPA_CLASH;
            end else if (!any_sel || cmd_sel != space_cmd_q) begin
               state_d = rpa_pkg::RPA_IDLE;
            end else if (!rw) begin
               state_d = rpa_pkg::RPA_WRITE;
            end
         end
         rpa_pkg::RPA_WRITE: begin
            if (both_sel) begin
               state_d = rpa_pkg::RPA_CLASH;
            end else if (!any_sel || cmd_sel != space_cmd_q) begin
               state_d = rpa_pkg::RPA_IDLE;
            end
         end
         rpa_pkg::RPA_CLASH: begin
            if (cs_n && cmd_n) begin
               state_d = rpa_pkg::RPA_IDLE;
            end
         end
         default: begin
            state_d = rpa_pkg::RPA_IDLE;
         end
      endcase
   end

   always_ff @(posedge core_clk_i) begin
      if (!resetn_i) begin
         state_q <= rpa_pkg::RPA_IDLE;
         space_cmd_q <= 1'b0;
      end else begin
         state_q <= state_d;
         space_cmd_q <= space_cmd_d;
      end
   end

   // ****************************************
   // Write lanes
   // ****************************************
   assign wr_lo = state_d == rpa_pkg::RPA_WRITE && !rw && !lo_n;
   assign wr_hi = state_d == rpa_pkg::RPA_WRITE && !rw && !hb_n;
   assign rel_hit = wr_lo && space_cmd_d
                    && addr_s[`RPA_CMD_AW-1:0] == `RPA_RESTART_LOC
                    && !data_s[`RPA_RESTART_BIT];

   always_ff @(posedge core_clk_i) begin
      if (!resetn_i) begin
         mem_wr_lo_o <= 1'b0;
         mem_wr_hi_o <= 1'b0;
         cmd_wr_lo_o <= 1'b0;
         cmd_wr_hi_o <= 1'b0;
      end else begin
         mem_wr_lo_o <= wr_lo && !space_cmd_d;
         mem_wr_hi_o <= wr_hi && !space_cmd_d;
         cmd_wr_lo_o <= wr_lo && space_cmd_d;
         cmd_wr_hi_o <= wr_hi && space_cmd_d;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (!resetn_i) begin
         acc_addr_o <= '0;
         acc_wdata_o <= '0;
      end else begin
         acc_addr_o <= addr_s;
         acc_wdata_o <= data_s;
      end
   end

   // ****************************************
   // Sequential pointer release
   // ****************************************
   always_ff @(posedge core_clk_i) begin
      if (!resetn_i) begin
         released_q <= 1'b0;
         seq_release_o <= 1'b0;
      end else begin
         released_q <= (released_q || rel_hit)
                       && state_d == rpa_pkg::RPA_WRITE;
         seq_release_o <= rel_hit && !released_q;
      end
   end

   // ****************************************
   // Read strobes and output drive
   // ****************************************
   always_ff @(posedge core_clk_i) begin
      if (!resetn_i) begin
         mem_rd_o <= 1'b0;
         cmd_rd_o <= 1'b0;
         data_oe_o <= '0;
      end else begin
         mem_rd_o <= state_d == rpa_pkg::RPA_READ && !space_cmd_d;
         cmd_rd_o <= state_d == rpa_pkg::RPA_READ && space_cmd_d;
         data_oe_o <= {{(DATA_W - `RPA_LANE_W){state_d == rpa_pkg::RPA_READ
                          && !oe_n && !hb_n}},
                       {`RPA_LANE_W{state_d == rpa_pkg::RPA_READ
                          && !oe_n && !lo_n}}};
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (!resetn_i) begin
         data_out_o <= '0;
      end else if (space_cmd_q) begin
         data_out_o <= cmd_rdata_i;
      end else begin
         data_out_o <= mem_rdata_i;
      end
   end

   // ****************************************
   // Select clash flag
   // ****************************************
   always_ff @(posedge core_clk_i) begin
      if (!resetn_i) begin
         select_error_o <= 1'b0;
      end else begin
         select_error_o <= state_d == rpa_pkg::RPA_CLASH;
      end
   end

endmodule // rpa_access_ctrl

/* src/rpa_pin_sync.sv */
// Purpose: Three stage pin synchroniser with agreement filter
// Assumes: Pins are asynchronous to core_clk_i
// Notes: Output changes once stages two and three agree
`timescale 1ns/10ps
module rpa_pin_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] RST_VAL = '0
) (
   input wire logic core_clk_i,
   input wire logic resetn_i,
   input wire logic [W-1:0] pin_i,
   output logic [W-1:0] level_o
);

   logic [W-1:0] s1_q;
   logic [W-1:0] s2_q;
   logic [W-1:0] s3_q;

   // ****************************************
   // Sync chain
   // ****************************************
   always_ff @(posedge core_clk_i) begin
      if (!resetn_i) begin
         s1_q <= RST_VAL;
         s2_q <= RST_VAL;
         s3_q <= RST_VAL;
      end else begin
         s1_q <= pin_i;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   // ****************************************
   // Agreement filter, per bit
   // ****************************************
   always_ff @(posedge core_clk_i) begin
      if (!resetn_i) begin
         level_o <= RST_VAL;
      end else begin
         level_o <= (s2_q & s3_q) | (level_o & (s2_q ^ s3_q));
      end
   end

endmodule // rpa_pin_sync
